/* File: design/xofp_regs.sv */
// Frequency program register bank behind a serial two-wire slave port
//
// Contract
// - Final divider code zero bypasses stage
// - Register 0 holds two loop factors
// - Fraction spread over registers 5 to 8
// - Divider applies only on register 9 write or soft reset
// - Fraction LSB is finest frequency step
// - Calibration trigger self clears, reads zero
// - Final divider codes map to 1..32
// - Soft reset restores defaults, self clears
`timescale 1ns/100ps
module xofp_regs
    import xofp_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h55  // Arbitrary bus address
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // Serial port pins
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe_n,
    // Synthesizer settings
    output logic [3:0]                 loop_comp_first,
    output logic [3:0]                 loop_comp_second,
    output xofp_fb_s                   fb_applied,
    output logic                       fb_update,
    output logic [9:0]                 vco_high_speed_divider,
    output logic [2:0]                 final_output_divider,
    output logic [5:0]                 final_divide_ratio,
    // Output stage and calibration
    output logic                       out_enable,
    output logic [1:0]                 disabled_level,
    output logic                       vco_calibrate_trigger
);

    // Reserved low addresses are refused at elaboration
    if (DEV_ADDR < 7'h08) begin : g_bad_addr
        $error("device address lies in the reserved range");
    end

    logic              scl_m_q, scl_s_q, scl_p_q;
    logic              sda_m_q, sda_s_q, sda_p_q;
    xofp_state_e       state_q;
    xofp_state_e       next_q;
    logic [3:0]        bit_cnt_q;
    logic [7:0]        shift_q;
    logic [7:0]        ptr_q;
    logic              ack_drv_q;
    logic              wr_stb_q;
    logic [7:0]        wr_addr_q;
    logic [7:0]        wr_data_q;
    logic [7:0]        loop_q;
    logic [XOFP_FRAC_W-1:0] frac_hold_q;
    logic [2:0]        int_low_q;
    logic [5:0]        int_up_q;
    logic [9:0]        vco_div_q;
    logic [2:0]        final_q;
    logic [5:0]        ratio_q;
    logic [1:0]        dis_lvl_q;
    logic              oe_q;
    logic              cal_q;
    xofp_fb_s          fb_q;
    logic              upd_q;
    logic              start_c, stop_c, rise_c, fall_c;
    logic [7:0]        in_byte_c;
    logic              soft_rst_c;

    // Current value of a register; unmapped and reserved bits read zero
    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        unique case (a)
            XOFP_REG_LOOP:    rd_byte = loop_q;
            XOFP_REG_FRAC0:   rd_byte = frac_hold_q[7:0];
            XOFP_REG_FRAC1:   rd_byte = frac_hold_q[15:8];
            XOFP_REG_FRAC2:   rd_byte = frac_hold_q[23:16];
            XOFP_REG_MIXED:   rd_byte = {int_low_q, frac_hold_q[28:24]};
            XOFP_REG_INT_UP:  rd_byte = {2'h0, int_up_q};
            XOFP_REG_VCO_LOW: rd_byte = vco_div_q[7:0];
            XOFP_REG_DIV_UP:  rd_byte = {1'b0, final_q, 2'h0, vco_div_q[9:8]};
            XOFP_REG_DIS_LVL: rd_byte = {2'h0, dis_lvl_q, 4'h0};
            XOFP_REG_OE_CAL:  rd_byte = {5'h00, oe_q, 2'h0};
            default:          rd_byte = 8'h00;
        endcase
    endfunction

    // Divide ratio of a final divider code
    function automatic logic [5:0] final_ratio(input logic [2:0] code);
        final_ratio = 6'(6'h01 << code);
    endfunction

    // Pin synchronisers; the previous sample gives edges without touching the first stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q} <= 6'h3F;
        end else begin
            {scl_p_q, scl_s_q, scl_m_q} <= {scl_s_q, scl_m_q, scl_i};
            {sda_p_q, sda_s_q, sda_m_q} <= {sda_s_q, sda_m_q, sda_i};
        end
    end
    // Bus conditions
    assign start_c   = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_c    = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    assign rise_c    = scl_s_q & ~scl_p_q;
    assign fall_c    = ~scl_s_q & scl_p_q;
    assign in_byte_c = {shift_q[6:0], sda_s_q};

    // Serial slave: address, register pointer, then data with auto-increment
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q   <= XOFP_IDLE;
            next_q    <= XOFP_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            ptr_q     <= 8'h00;
            ack_drv_q <= 1'b0;
            sda_oe_n  <= 1'b1;
            wr_stb_q  <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_stb_q <= 1'b0;
            if (stop_c) begin
                state_q  <= XOFP_IDLE;
                sda_oe_n <= 1'b1;
            end else if (start_c) begin
                state_q   <= XOFP_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe_n  <= 1'b1;
            end else begin
                unique case (state_q)
                    XOFP_IDLE: ;
                    XOFP_ADDR, XOFP_REG, XOFP_WDATA: begin
                        if (rise_c) begin
                            shift_q   <= in_byte_c;
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            if (bit_cnt_q == 4'h7) begin
                                ack_drv_q <= 1'b0;
                                state_q   <= XOFP_ACK;
                                if (state_q == XOFP_ADDR) begin
                                    if (in_byte_c[7:1] != DEV_ADDR) begin
                                        state_q <= XOFP_IDLE;
                                    end
                                    next_q <= in_byte_c[0] ? XOFP_RDATA : XOFP_REG;
                                end else if (state_q == XOFP_REG) begin
                                    ptr_q  <= in_byte_c;
                                    next_q <= XOFP_WDATA;
                                end else begin
                                    wr_stb_q  <= 1'b1;
                                    wr_addr_q <= ptr_q;
                                    wr_data_q <= in_byte_c;
                                    ptr_q     <= ptr_q + 8'h01;
                                    next_q    <= XOFP_WDATA;
                                end
                            end
                        end
                    end
                    XOFP_ACK: begin
                        if (fall_c) begin
                            if (!ack_drv_q) begin
                                ack_drv_q <= 1'b1;
                                sda_oe_n  <= 1'b0;
                            end else begin
                                state_q   <= next_q;
                                bit_cnt_q <= 4'h0;
                                if (next_q == XOFP_RDATA) begin
                                    sda_oe_n <= 1'(rd_byte(ptr_q) >> 7);
                                    shift_q  <= rd_byte(ptr_q) << 1;
                                end else begin
                                    sda_oe_n <= 1'b1;
                                end
                            end
                        end
                    end
                    XOFP_RDATA: begin
                        if (rise_c) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (fall_c) begin
                            if (bit_cnt_q == 4'h8) begin
                                sda_oe_n <= 1'b1;
                                state_q  <= XOFP_MACK;
                            end else begin
                                sda_oe_n <= shift_q[7];
                                shift_q  <= {shift_q[6:0], 1'b0};
                            end
                        end
                    end
                    XOFP_MACK: begin
                        // A missing acknowledge ends the read burst
                        if (rise_c) begin
                            if (!sda_s_q) begin
                                ptr_q     <= ptr_q + 8'h01;
                                shift_q   <= rd_byte(ptr_q + 8'h01);
                                bit_cnt_q <= 4'h0;
                                state_q   <= XOFP_RDATA;
                            end else begin
                                state_q <= XOFP_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Open-drain line only ever pulled low
    assign sda_o = 1'b0;

    assign soft_rst_c = wr_stb_q && wr_addr_q == XOFP_REG_SOFT_RST && wr_data_q[XOFP_SOFT_RST_BIT];

    // Register bank; soft reset bit is never stored, so it reads back zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loop_q      <= XOFP_LOOP_RST;
            frac_hold_q <= XOFP_FRAC_RST;
            int_low_q   <= XOFP_INT_RST[2:0];
            int_up_q    <= XOFP_INT_RST[8:3];
            vco_div_q   <= XOFP_VCO_DIV_RST;
            final_q     <= XOFP_FINAL_RST;
            ratio_q     <= final_ratio(XOFP_FINAL_RST);
            dis_lvl_q   <= XOFP_DIS_LVL_RST;
            oe_q        <= XOFP_OE_RST;
        end else if (soft_rst_c) begin
            loop_q      <= XOFP_LOOP_RST;
            frac_hold_q <= XOFP_FRAC_RST;
            int_low_q   <= XOFP_INT_RST[2:0];
            int_up_q    <= XOFP_INT_RST[8:3];
            vco_div_q   <= XOFP_VCO_DIV_RST;
            final_q     <= XOFP_FINAL_RST;
            ratio_q     <= final_ratio(XOFP_FINAL_RST);
            dis_lvl_q   <= XOFP_DIS_LVL_RST;
            oe_q        <= XOFP_OE_RST;
        end else if (wr_stb_q) begin
            unique case (wr_addr_q)
                XOFP_REG_LOOP:    loop_q <= wr_data_q;
                XOFP_REG_FRAC0:   frac_hold_q[7:0] <= wr_data_q;
                XOFP_REG_FRAC1:   frac_hold_q[15:8] <= wr_data_q;
                XOFP_REG_FRAC2:   frac_hold_q[23:16] <= wr_data_q;
                XOFP_REG_MIXED: begin
                    frac_hold_q[28:24] <= wr_data_q[4:0];
                    int_low_q          <= wr_data_q[7:XOFP_MIX_INT_LSB];
                end
                XOFP_REG_INT_UP:  int_up_q <= wr_data_q[5:0];
                XOFP_REG_VCO_LOW: vco_div_q[7:0] <= wr_data_q;
                XOFP_REG_DIV_UP: begin
                    vco_div_q[9:8] <= wr_data_q[1:0];
                    final_q        <= wr_data_q[6:XOFP_FINAL_DIV_LSB];
                    // Reserved codes leave the previous ratio running
                    if (wr_data_q[6:XOFP_FINAL_DIV_LSB] <= XOFP_FINAL_MAX) begin
                        ratio_q <= final_ratio(wr_data_q[6:XOFP_FINAL_DIV_LSB]);
                    end
                end
                XOFP_REG_DIS_LVL: dis_lvl_q <= wr_data_q[5:XOFP_DIS_LVL_LSB];
                XOFP_REG_OE_CAL:  oe_q <= wr_data_q[XOFP_OE_BIT];
                default: ;
            endcase
        end
    end

    // Whole divider goes to the synthesizer at once on the upper integer write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fb_q  <= '{int_part: XOFP_INT_RST, frac_part: XOFP_FRAC_RST};
            upd_q <= 1'b0;
        end else begin
            upd_q <= 1'b0;
            if (soft_rst_c) begin
                fb_q  <= '{int_part: XOFP_INT_RST, frac_part: XOFP_FRAC_RST};
                upd_q <= 1'b1;
            end else if (wr_stb_q && wr_addr_q == XOFP_REG_INT_UP) begin
                // Fraction LSB lands on bit 0, the finest frequency step
                fb_q  <= '{int_part: {wr_data_q[5:0], int_low_q}, frac_part: frac_hold_q};
                upd_q <= 1'b1;
            end
        end
    end

    // Calibration trigger is a one-cycle pulse, never stored
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cal_q <= 1'b0;
        end else begin
            cal_q <= wr_stb_q && wr_addr_q == XOFP_REG_OE_CAL && wr_data_q[XOFP_CAL_BIT];
        end
    end

    // Outputs straight from the bank
    assign loop_comp_first        = loop_q[7:XOFP_LOOP_FIRST_LSB];
    assign loop_comp_second       = loop_q[3:0];
    assign fb_applied             = fb_q;
    assign fb_update              = upd_q;
    assign vco_high_speed_divider = vco_div_q;
    assign final_output_divider   = final_q;
    assign final_divide_ratio     = ratio_q;
    assign out_enable             = oe_q;
    assign disabled_level         = dis_lvl_q;
    assign vco_calibrate_trigger  = cal_q;

    a_cal_one_cycle: assert property (@(posedge clk) disable iff (sys_rst) cal_q |=> !cal_q)
        else $error("calibration trigger held longer than one cycle");
    a_cal_reads_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (rd_byte(XOFP_REG_OE_CAL) & 8'h01) == 8'h00)
        else $error("calibration bit read back as one");
    a_fb_only_upd: assert property (@(posedge clk) disable iff (sys_rst) $changed(fb_q) |-> upd_q)
        else $error("feedback divider changed without an update");
    a_upd_cause: assert property (@(posedge clk) disable iff (sys_rst)
        upd_q |-> $past(wr_stb_q && (wr_addr_q == XOFP_REG_INT_UP || soft_rst_c)))
        else $error("divider update without upper integer write");
    a_bypass_code: assert property (@(posedge clk) disable iff (sys_rst) final_q == 3'h0 |-> ratio_q == 6'h01)
        else $error("code zero does not bypass final divider");
    a_final_decode: assert property (@(posedge clk) disable iff (sys_rst)
        final_q <= XOFP_FINAL_MAX |-> ratio_q == final_ratio(final_q))
        else $error("final divider ratio decoded wrongly");
    a_loop_split: assert property (@(posedge clk) disable iff (sys_rst)
        wr_stb_q && wr_addr_q == XOFP_REG_LOOP |=>
        loop_comp_first == $past(wr_data_q[7:4]) && loop_comp_second == $past(wr_data_q[3:0]))
        else $error("loop factors not split into nibbles");
    a_frac_top: assert property (@(posedge clk) disable iff (sys_rst)
        wr_stb_q && wr_addr_q == XOFP_REG_MIXED |=> frac_hold_q[28:24] == $past(wr_data_q[4:0])
        && int_low_q == $past(wr_data_q[7:5]) && $stable(fb_q))
        else $error("mixed divider byte stored wrongly");
    a_soft_reset: assert property (@(posedge clk) disable iff (sys_rst)
        soft_rst_c |=> oe_q == XOFP_OE_RST && vco_div_q == XOFP_VCO_DIV_RST && loop_q == XOFP_LOOP_RST
        && rd_byte(XOFP_REG_SOFT_RST) == 8'h00)
        else $error("soft reset did not restore defaults");
endmodule

/* File: design/xofp_pkg.sv */
// Register map, field layout, reset values and carrier types of the frequency program bank
package xofp_pkg;

    // Register numbers (byte locations on the serial port)
    localparam logic [7:0] XOFP_REG_LOOP     = 8'h00;
    localparam logic [7:0] XOFP_REG_FRAC0    = 8'h05;
    localparam logic [7:0] XOFP_REG_FRAC1    = 8'h06;
    localparam logic [7:0] XOFP_REG_FRAC2    = 8'h07;
    localparam logic [7:0] XOFP_REG_MIXED    = 8'h08;
    localparam logic [7:0] XOFP_REG_INT_UP   = 8'h09;
    localparam logic [7:0] XOFP_REG_VCO_LOW  = 8'h0A;
    localparam logic [7:0] XOFP_REG_DIV_UP   = 8'h0B;
    localparam logic [7:0] XOFP_REG_DIS_LVL  = 8'h0E;
    localparam logic [7:0] XOFP_REG_SOFT_RST = 8'h80;
    localparam logic [7:0] XOFP_REG_OE_CAL   = 8'h84;

    // Field positions
    localparam int XOFP_LOOP_FIRST_LSB = 4;
    localparam int XOFP_MIX_INT_LSB    = 5;
    localparam int XOFP_FINAL_DIV_LSB  = 4;
    localparam int XOFP_DIS_LVL_LSB    = 4;
    localparam int XOFP_SOFT_RST_BIT   = 7;
    localparam int XOFP_OE_BIT         = 2;
    localparam int XOFP_CAL_BIT        = 0;
    localparam int XOFP_FRAC_W         = 29;
    localparam int XOFP_INT_W          = 9;

    // Reset values (factory frequency plan)
    localparam logic [7:0]             XOFP_LOOP_RST    = 8'h33;
    localparam logic [XOFP_FRAC_W-1:0] XOFP_FRAC_RST    = 29'h02A4_4557;
    localparam logic [XOFP_INT_W-1:0]  XOFP_INT_RST     = 9'h044;
    localparam logic [9:0]             XOFP_VCO_DIV_RST = 10'h02A;
    localparam logic [2:0]             XOFP_FINAL_RST   = 3'h0;
    localparam logic [1:0]             XOFP_DIS_LVL_RST = 2'h0;
    localparam logic                   XOFP_OE_RST      = 1'b1;
    localparam logic [2:0]             XOFP_FINAL_MAX   = 3'h5;

    // Feedback divider as handed to the synthesizer
    typedef struct packed {
        logic [XOFP_INT_W-1:0]  int_part;
        logic [XOFP_FRAC_W-1:0] frac_part;
    } xofp_fb_s;

    // Receive engine states
    typedef enum logic [2:0] {
        XOFP_IDLE, XOFP_ADDR, XOFP_REG, XOFP_WDATA, XOFP_ACK, XOFP_RDATA, XOFP_MACK
    } xofp_state_e;

endpackage

/* File: verif/xofp_host.sv */
// Two-wire bus host model that writes and reads the frequency bank
`timescale 1ns/100ps
module xofp_host #(
    parameter logic [6:0] DEV = 7'h55  // Arbitrary bus address
) (
    // Clock
    input  wire logic clk,
    // Bus pins, clock driven, data open drain
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda
);
    logic [7:0] rd_byte = 8'h00;
    logic       rd_valid = 1'b0;
    logic       ack_ok = 1'b0;
    // Idle bus, clock stands still between frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Quarter bit of two clocks gives the 200 ns bus period
    task automatic step(input logic s, input logic d);
        repeat (2) @(posedge clk);
        scl <= s;
        sda_drv <= d;
    endtask
    // Data moves only while clock is low, sampled in the middle of the high phase
    task automatic bit_io(input logic b, output logic r);
        step(1'b0, b);
        step(1'b1, b);
        repeat (2) @(posedge clk);
        r = sda;
        step(1'b0, b);
    endtask
    // Works from idle and as a repeated start alike
    task automatic start;
        step(scl, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        ack_ok = 1'b1;
    endtask
    task automatic stop;
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    // Byte out, then acknowledge from the device
    task automatic put(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack_ok = ack_ok & !r;
    endtask
    // Byte in, acknowledged unless it is the last of the burst
    task automatic get(input logic last);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, rd_byte[i]);
        bit_io(last, r);
        rd_valid <= 1'b1;
        @(posedge clk);
        rd_valid <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] r);
        start;
        put({DEV, 1'b0});
        put(r);
    endtask
    task automatic wr1(input logic [7:0] r, input logic [7:0] d);
        frame(r);
        put(d);
        stop;
    endtask
    // Pointer advances per byte, so one frame fills four registers
    task automatic wr4(input logic [7:0] r, input logic [31:0] d);
        frame(r);
        for (int i = 0; i < 4; i++)
            put(d[8*i +: 8]);
        stop;
    endtask
    // Burst of n bytes from the pointer, which moves per byte
    task automatic rd1(input logic [7:0] r, input int n);
        frame(r);
        start;
        put({DEV, 1'b1});
        for (int i = 1; i <= n; i++)
            get(i == n);
        stop;
    endtask
endmodule

/* File: verif/xofp_regs_tb_top.sv */
// Self-checking bench for the frequency program bank
`timescale 1ns/100ps
module xofp_regs_tb_top
    import xofp_pkg::*;
;
    // Design pins and the wired-AND data line with its pull-up
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        scl, sda_drv, sda_o, sda_oe_n, fb_update, out_enable, vco_calibrate_trigger;
    logic [3:0]  loop_comp_first, loop_comp_second;
    logic [9:0]  vco_high_speed_divider;
    logic [2:0]  final_output_divider;
    logic [5:0]  final_divide_ratio;
    logic [1:0]  disabled_level;
    xofp_fb_s    fb_applied;
    wire         sda = sda_drv & (sda_oe_n | sda_o);
    wire  [29:0] lv_now = {loop_comp_first, loop_comp_second, vco_high_speed_divider, final_output_divider,
                           final_divide_ratio, out_enable, disabled_level};
    // Predicted bank contents and notes of expected results
    logic [7:0]  sh_loop;
    logic [9:0]  sh_vco, vco;
    logic [2:0]  sh_fin;
    logic [5:0]  sh_ratio;
    logic [1:0]  sh_dis;
    logic        sh_oe;
    logic [31:0] rnd, w;
    xofp_fb_s    sh_hold, sh_app;
    xofp_fb_s    exp_fb[$];
    logic [7:0]  exp_rd[$];
    int          n_fail = 0, checked = 0, n_cal = 0, n_cal_exp = 0, seed = 58200;
    logic [7:0]  addrs[12] = '{8'h00, 8'h01, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0E, 8'h80, 8'h84};
    initial begin
        forever #12.5 clk = ~clk;
    end
    xofp_regs dut_u (.clk(clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .loop_comp_first(loop_comp_first), .loop_comp_second(loop_comp_second), .fb_applied(fb_applied),
        .fb_update(fb_update), .vco_high_speed_divider(vco_high_speed_divider),
        .final_output_divider(final_output_divider), .final_divide_ratio(final_divide_ratio),
        .out_enable(out_enable), .disabled_level(disabled_level), .vco_calibrate_trigger(vco_calibrate_trigger));
    xofp_host #(.DEV(7'h55)) host_u (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t byte %h, expected %h", $time, g, e);
        end
    endtask
    task automatic cmpv(input logic [67:0] g, input logic [67:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t outputs %h, expected %h", $time, g, e);
        end
    endtask
    // Reserved bits and unmapped places read zero
    function automatic logic [7:0] img(input logic [7:0] r);
        case (r)
            XOFP_REG_LOOP:    return sh_loop;
            XOFP_REG_FRAC0:   return sh_hold.frac_part[7:0];
            XOFP_REG_FRAC1:   return sh_hold.frac_part[15:8];
            XOFP_REG_FRAC2:   return sh_hold.frac_part[23:16];
            XOFP_REG_MIXED:   return {sh_hold.int_part[2:0], sh_hold.frac_part[28:24]};
            XOFP_REG_INT_UP:  return {2'h0, sh_hold.int_part[8:3]};
            XOFP_REG_VCO_LOW: return sh_vco[7:0];
            XOFP_REG_DIV_UP:  return {1'b0, sh_fin, 2'h0, sh_vco[9:8]};
            XOFP_REG_DIS_LVL: return {2'h0, sh_dis, 4'h0};
            XOFP_REG_OE_CAL:  return {5'h00, sh_oe, 2'h0};
            default:          return 8'h00;
        endcase
    endfunction
    task automatic defaults(input logic push);
        sh_loop = XOFP_LOOP_RST;
        sh_hold = {XOFP_INT_RST, XOFP_FRAC_RST};
        sh_app = sh_hold;
        sh_vco = XOFP_VCO_DIV_RST;
        sh_fin = XOFP_FINAL_RST;
        sh_ratio = 6'h01 << XOFP_FINAL_RST;
        sh_dis = XOFP_DIS_LVL_RST;
        sh_oe = XOFP_OE_RST;
        if (push) exp_fb.push_back(sh_hold);
    endtask
    // Predict the effect of one register write before it is sent
    task automatic note(input logic [7:0] r, input logic [7:0] d);
        case (r)
            XOFP_REG_LOOP:     sh_loop = d;
            XOFP_REG_FRAC0:    sh_hold.frac_part[7:0] = d;
            XOFP_REG_FRAC1:    sh_hold.frac_part[15:8] = d;
            XOFP_REG_FRAC2:    sh_hold.frac_part[23:16] = d;
            XOFP_REG_MIXED:    {sh_hold.int_part[2:0], sh_hold.frac_part[28:24]} = d;
            XOFP_REG_INT_UP: begin
                sh_hold.int_part[8:3] = d[5:0];
                sh_app = sh_hold;
                exp_fb.push_back(sh_hold);
            end
            XOFP_REG_VCO_LOW:  sh_vco[7:0] = d;
            XOFP_REG_DIV_UP: begin
                sh_vco[9:8] = d[1:0];
                sh_fin = d[6:4];
                if (d[6:4] <= XOFP_FINAL_MAX) sh_ratio = 6'h01 << d[6:4];
            end
            XOFP_REG_DIS_LVL:  sh_dis = d[5:4];
            XOFP_REG_SOFT_RST: if (d[7]) defaults(1'b1);
            XOFP_REG_OE_CAL: begin
                sh_oe = d[2];
                n_cal_exp += d[0];
            end
            default: ;
        endcase
    endtask
    task automatic wreg(input logic [7:0] r, input logic [7:0] d);
        note(r, d);
        host_u.wr1(r, d);
        cmp8({7'h00, host_u.ack_ok}, 8'h01);
    endtask
    task automatic wfrac(input logic [31:0] v);
        for (int i = 0; i < 4; i++)
            note(XOFP_REG_FRAC0 + 8'(i), v[8*i +: 8]);
        host_u.wr4(XOFP_REG_FRAC0, v);
        cmp8({7'h00, host_u.ack_ok}, 8'h01);
    endtask
    task automatic rd_chk(input logic [7:0] r);
        exp_rd.push_back(img(r));
        host_u.rd1(r, 1);
    endtask
    task automatic chk;
        cmpv({fb_applied, lv_now}, {sh_app, sh_loop, sh_vco, sh_fin, sh_ratio, sh_oe, sh_dis});
    endtask
    // Oldest note is matched whenever a result appears; a result with no note fails
    always @(posedge clk) begin
        if (host_u.rd_valid === 1'b1)
            cmp8(host_u.rd_byte, exp_rd.size() > 0 ? exp_rd.pop_front() : ~host_u.rd_byte);
        if (fb_update === 1'b1)
            cmpv({30'h0, fb_applied}, {30'h0, exp_fb.size() > 0 ? exp_fb.pop_front() : ~fb_applied});
        if (vco_calibrate_trigger === 1'b1) n_cal++;
    end
    initial begin
        defaults(1'b0);
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        foreach (addrs[i]) rd_chk(addrs[i]);
        chk;
        $display("test reset values done");
        host_u.frame(8'h2A);
        host_u.stop;
        // A foreign bus address gets no acknowledge
        host_u.start;
        host_u.put({7'h2A, 1'b0});
        host_u.stop;
        cmp8({7'h00, host_u.ack_ok}, 8'h00);
        wreg(8'h01, 8'h5A);
        rd_chk(8'h01);
        $display("test address and unmapped done");
        wreg(XOFP_REG_OE_CAL, img(XOFP_REG_OE_CAL) & 8'hFB);
        rnd = $random(seed);
        wreg(XOFP_REG_LOOP, rnd[7:0]);
        wreg(XOFP_REG_DIS_LVL, 8'h10);
        rnd = $random(seed);
        wfrac(rnd);
        chk;
        rnd = $random(seed);
        wreg(XOFP_REG_INT_UP, {2'h0, rnd[5:0]});
        vco = 10'(10 + 2 * (rnd % 507));
        wreg(XOFP_REG_VCO_LOW, vco[7:0]);
        rd_chk(XOFP_REG_DIV_UP);
        wreg(XOFP_REG_DIV_UP, (img(XOFP_REG_DIV_UP) & 8'hFC) | {6'h00, vco[9:8]});
        wreg(XOFP_REG_OE_CAL, img(XOFP_REG_OE_CAL) | 8'h01);
        wreg(XOFP_REG_OE_CAL, img(XOFP_REG_OE_CAL) | 8'h04);
        rd_chk(XOFP_REG_OE_CAL);
        cmp8(8'(n_cal), 8'(n_cal_exp));
        chk;
        $display("test large retune done");
        for (int c = 0; c < 8; c++) begin
            wreg(XOFP_REG_DIV_UP, {1'b0, 3'(c), 2'h0, sh_vco[9:8]});
            chk;
        end
        $display("test final divider codes done");
        // Small corrections step the existing fraction
        repeat (3) begin
            rnd = $random(seed);
            w = {sh_hold.int_part[2:0], sh_hold.frac_part} + {{24{rnd[7]}}, rnd[7:0]};
            wfrac(w);
            wreg(XOFP_REG_INT_UP, {2'h0, sh_hold.int_part[8:3]});
            chk;
        end
        $display("test small retune done");
        wreg(XOFP_REG_SOFT_RST, 8'h80);
        foreach (addrs[i]) rd_chk(addrs[i]);
        chk;
        exp_rd.push_back(img(XOFP_REG_FRAC0));
        exp_rd.push_back(img(XOFP_REG_FRAC1));
        host_u.rd1(XOFP_REG_FRAC0, 2);
        cmp8(8'(exp_rd.size() + exp_fb.size()), 8'h00);
        $display("test soft reset done");
        report_and_stop;
    end
    // Whole run takes about 0.4 ms, a fifth of the 2 ms limit
    initial begin
        #2000000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop;
    end
    task automatic report_and_stop;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
endmodule
